// ### ciex_pkg.sv
package ciex_pkg;
  // Register bus offsets (byte addresses, one aligned word each)
  localparam logic [7:0] CIEX_CTRL_OFF = 8'h00;
  localparam logic [7:0] CIEX_INSTR_OFF = 8'h04;
  localparam logic [7:0] CIEX_W_OFF = 8'h08;
  localparam logic [7:0] CIEX_STATUS_OFF = 8'h0C;
  localparam logic [7:0] CIEX_WDT_OFF = 8'h10;
  localparam logic [7:0] CIEX_PRE_OFF = 8'h14;
  localparam logic [7:0] CIEX_FADDR_OFF = 8'h18;
  localparam logic [7:0] CIEX_FDATA_OFF = 8'h1C;
  // Status register field positions
  localparam int CIEX_Z_BIT = 2;
  localparam int CIEX_PWRDN_BIT = 3;
  localparam int CIEX_TMOUT_BIT = 4;
  // Control register field positions
  localparam int CIEX_PRE_OWN_BIT = 0;
  localparam int CIEX_WDT_EN_BIT = 1;
  localparam int CIEX_TOUT_BIT = 2;
  // Reset values
  localparam logic [7:0] CIEX_STATUS_RST = 8'h18;
  localparam logic [7:0] CIEX_ZERO8 = 8'h00;
  localparam logic [4:0] CIEX_FILE_LAST = 5'h1F;
  // Opcode patterns (12-bit words; 6- and 4-bit top fields)
  localparam logic [11:0] CIEX_CLEAR_W_OP = 12'h040;
  localparam logic [11:0] CIEX_WDOG_CLEAR_OP = 12'h004;
  localparam logic [5:0] CIEX_INC_TOP = 6'h0A;
  localparam logic [5:0] CIEX_INCSZ_TOP = 6'h0F;
  localparam logic [5:0] CIEX_OR_FILE_TOP = 6'h04;
  localparam logic [3:0] CIEX_OR_LIT_TOP = 4'hD;
  typedef enum logic [1:0] {
    CIEX_IDLE = 2'b00,
    CIEX_SKIP = 2'b01
  } ciex_state_t;
endpackage

// ### ciex_alu_if.sv
`timescale 1ns/1ps
interface ciex_alu_if;
  logic [11:0] instr;
  logic [7:0] w_val;
  logic [7:0] f_val;
  logic [7:0] result;
  logic res_zero;
  logic to_w;
  logic to_f;
  logic sets_z;
  logic is_wdog_clear;
  logic skip_req;
  modport core (output instr, w_val, f_val,
    input result, res_zero, to_w, to_f, sets_z, is_wdog_clear, skip_req);
  modport alu (input instr, w_val, f_val,
    output result, res_zero, to_w, to_f, sets_z, is_wdog_clear, skip_req);
endinterface

// ### ciex_alu.sv
`timescale 1ns/1ps
module ciex_alu
  import ciex_pkg::*;
(
  ciex_alu_if.alu a // Decode and datapath link
);
  wire [7:0] k_lit = a.instr[7:0];
  wire d_bit = a.instr[5];
  // Opcode decode
  wire op_clear_w = (a.instr == CIEX_CLEAR_W_OP);
  wire op_wdog_clear = (a.instr == CIEX_WDOG_CLEAR_OP);
  wire op_inc = (a.instr[11:6] == CIEX_INC_TOP);
  wire op_incsz = (a.instr[11:6] == CIEX_INCSZ_TOP);
  wire op_or_file = (a.instr[11:6] == CIEX_OR_FILE_TOP);
  wire op_or_lit = (a.instr[11:8] == CIEX_OR_LIT_TOP);
  wire f_form = op_inc | op_incsz | op_or_file;
  wire [7:0] inc_val = a.f_val + 8'h01;
  // Result selection
  assign a.result = op_clear_w ? CIEX_ZERO8 :
    (op_inc | op_incsz) ? inc_val :
    op_or_file ? (a.w_val | a.f_val) :
    op_or_lit ? (a.w_val | k_lit) : CIEX_ZERO8;
  assign a.res_zero = (a.result == CIEX_ZERO8);
  // Destination: d=0 to working register, d=1 back to file
  assign a.to_w = op_clear_w | op_or_lit | (f_form & ~d_bit);
  assign a.to_f = f_form & d_bit;
  // Skip form leaves flags untouched
  assign a.sets_z = op_clear_w | op_inc | op_or_file | op_or_lit;
  assign a.is_wdog_clear = op_wdog_clear;
  assign a.skip_req = op_incsz & a.res_zero;
endmodule

// ### ciex_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Clear working register, set zero flag
// - Watchdog clear zeroes watchdog counter
// - Prescaler zeroed only when owned by watchdog
// - Watchdog clear sets timeout and powerdown
// - Increment file register, zero flag only
// - Five-bit file address; d selects destination
// - Skip form: no flags, nop on zero
// - OR literal into working register
// - OR file with working register
// - Timeout is status bit 4, powerdown 3
// - Watchdog timeout clears timeout status
module ciex_top
  import ciex_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic skip_ff, // Next fetched instruction discarded
  output logic [7:0] wreg_ff // Working register
);
  ciex_alu_if alu_bus();
  ciex_state_t state_ff;
  ciex_state_t nxt_state;
  logic [7:0] status_ff;
  logic [7:0] wdt_ff;
  logic [7:0] pre_ff;
  logic pre_own_ff;
  logic wdt_en_ff;
  logic [4:0] faddr_ff;
  logic [7:0] file_mem [0:31];
  logic rdy_ff;
  logic err_ff;
  logic [31:0] rdata_ff;

  ciex_alu i_ciex_alu (
    .a(alu_bus.alu)
  );

  // APB decode; one wait state so every answer is registered
  wire acc = psel & penable & rdy_ff;
  wire wr = acc & pwrite;
  wire sel_ctrl = (paddr == CIEX_CTRL_OFF);
  wire sel_instr = (paddr == CIEX_INSTR_OFF);
  wire sel_w = (paddr == CIEX_W_OFF);
  wire sel_stat = (paddr == CIEX_STATUS_OFF);
  wire sel_wdt = (paddr == CIEX_WDT_OFF);
  wire sel_pre = (paddr == CIEX_PRE_OFF);
  wire sel_fa = (paddr == CIEX_FADDR_OFF);
  wire sel_fd = (paddr == CIEX_FDATA_OFF);
  wire mapped = sel_ctrl | sel_instr | sel_w | sel_stat | sel_wdt |
    sel_pre | sel_fa | sel_fd;
  // Instruction issue: a write to the instruction register executes it unless a skip is pending
  wire issue = wr & sel_instr;
  wire exec = issue & (state_ff == CIEX_IDLE);
  wire squash = issue & (state_ff == CIEX_SKIP);
  wire tout = wr & sel_ctrl & pwdata[CIEX_TOUT_BIT] & wdt_en_ff;
  wire [4:0] fsel = pwdata[4:0];

  // Operands to the datapath
  assign alu_bus.instr = pwdata[11:0];
  assign alu_bus.w_val = wreg_ff;
  assign alu_bus.f_val = file_mem[fsel];

  wire do_wdog_clear = exec & alu_bus.is_wdog_clear;
  wire [7:0] ctrl_rd = {5'h00, 1'b0, wdt_en_ff, pre_own_ff};

  // Read mux
  wire [7:0] rd_byte = sel_ctrl ? ctrl_rd :
    sel_instr ? {7'h00, skip_ff} :
    sel_w ? wreg_ff :
    sel_stat ? status_ff :
    sel_wdt ? wdt_ff :
    sel_pre ? pre_ff :
    sel_fa ? {3'h0, faddr_ff} :
    sel_fd ? file_mem[faddr_ff] : CIEX_ZERO8;

  // Skip state: held until the next instruction write, which is discarded
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CIEX_IDLE: begin
        if (exec && alu_bus.skip_req) begin
          nxt_state = CIEX_SKIP;
        end
      end
      CIEX_SKIP: begin
        if (squash) begin
          nxt_state = CIEX_IDLE;
        end
      end
      default: nxt_state = CIEX_IDLE;
    endcase
  end

  // Bus handshake and state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      state_ff <= CIEX_IDLE;
      skip_ff <= 1'b0;
    end else begin
      rdy_ff <= psel & penable & ~rdy_ff;
      err_ff <= psel & penable & ~rdy_ff & ~mapped;
      rdata_ff <= {24'h000000, rd_byte};
      state_ff <= nxt_state;
      skip_ff <= (nxt_state == CIEX_SKIP);
    end
  end

  // Working register and configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg_ff <= CIEX_ZERO8;
      pre_own_ff <= 1'b0;
      wdt_en_ff <= 1'b0;
      faddr_ff <= 5'h00;
    end else begin
      if (exec && alu_bus.to_w) begin
        wreg_ff <= alu_bus.result;
      end else if (wr && sel_w) begin
        wreg_ff <= pwdata[7:0];
      end
      if (wr && sel_ctrl) begin
        pre_own_ff <= pwdata[CIEX_PRE_OWN_BIT];
        wdt_en_ff <= pwdata[CIEX_WDT_EN_BIT];
      end
      if (wr && sel_fa) begin
        faddr_ff <= pwdata[4:0];
      end
    end
  end

  // File registers; no reset, contents hold across instructions
  always_ff @(posedge pclk) begin
    if (exec && alu_bus.to_f) begin
      file_mem[fsel] <= alu_bus.result;
    end else if (wr && sel_fd) begin
      file_mem[faddr_ff] <= pwdata[7:0];
    end
  end

  // Status bits: zero flag, timeout, powerdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= CIEX_STATUS_RST;
    end else begin
      if (exec && alu_bus.sets_z) begin
        status_ff[CIEX_Z_BIT] <= alu_bus.res_zero;
      end
      if (tout) begin
        status_ff[CIEX_TMOUT_BIT] <= 1'b0;
      end else if (do_wdog_clear) begin
        status_ff[CIEX_TMOUT_BIT] <= 1'b1;
        status_ff[CIEX_PWRDN_BIT] <= 1'b1;
      end else if (wr && sel_stat) begin
        status_ff[CIEX_Z_BIT] <= pwdata[CIEX_Z_BIT];
      end
    end
  end

  // Watchdog counter and shared prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_ff <= CIEX_ZERO8;
      pre_ff <= CIEX_ZERO8;
    end else begin
      if (do_wdog_clear || tout) begin
        wdt_ff <= CIEX_ZERO8;
      end else if (wr && sel_wdt) begin
        wdt_ff <= pwdata[7:0];
      end
      if (do_wdog_clear && pre_own_ff) begin
        pre_ff <= CIEX_ZERO8;
      end else if (wr && sel_pre) begin
        pre_ff <= pwdata[7:0];
      end
    end
  end

  assign pready = rdy_ff;
  assign pslverr = err_ff;
  assign prdata = rdata_ff;
endmodule

// ### ciex_properties.sv
`timescale 1ns/1ps
module ciex_properties
  import ciex_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic skip_ff, // Skip pending
  input wire logic [7:0] wreg_ff // Working reg
);
  // Instruction issue at the completing access
  wire iw = psel && penable && pready && pwrite && paddr == CIEX_INSTR_OFF;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer timing and refusal
  ready_one_a: assert property (pready |=> !pready)
    else $error("ready held");
  ready_wait_a: assert property (psel && $rose(penable) |=> pready)
    else $error("ready late");
  // Unmapped: beyond the last word or not word aligned
  err_map_a: assert property (pready |->
    pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0))
    else $error("bad error flag");
  // Instruction effects on W and skip
  clr_w_a: assert property (
    iw && !skip_ff && pwdata[11:0] == CIEX_CLEAR_W_OP
    |=> wreg_ff == 8'h00) else $error("clear W failed");
  or_lit_a: assert property (
    iw && !skip_ff && pwdata[11:8] == CIEX_OR_LIT_TOP |=>
    wreg_ff == ($past(wreg_ff) | $past(pwdata[7:0])))
    else $error("OR literal wrong");
  skip_eat_a: assert property (iw && skip_ff |=> !skip_ff &&
    $stable(wreg_ff)) else $error("skip not taken");
  skip_src_a: assert property ($rose(skip_ff) |->
    $past(iw && pwdata[11:6] == CIEX_INCSZ_TOP))
    else $error("spurious skip");
  w_quiet_a: assert property ($changed(wreg_ff) |->
    $past(pready && pwrite)) else $error("W changed idle");
  // Main scenarios
  cover property (iw && pwdata[11:0] == CIEX_WDOG_CLEAR_OP);
  cover property (iw && skip_ff);
  cover property (pslverr);
endmodule

bind ciex_top ciex_properties i_ciex_properties (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .skip_ff, .wreg_ff);

// ### ciex_top_tb_top.sv
`timescale 1ns/1ps
module ciex_top_tb_top;
  import ciex_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, skip_ff, slv;
  logic [7:0] paddr = 8'h00, wreg_ff;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int err_count = 0, checks_done = 0;
  // Rows: write flag, address, write data or expected read data
  logic [40:0] rows [] = '{{1'h0, 8'h0C, 32'h18},
    {1'h1, 8'h08, 32'h5A}, {1'h1, 8'h04, 32'h040},
    {1'h0, 8'h08, 32'h00}, {1'h0, 8'h0C, 32'h1C},
    {1'h1, 8'h04, 32'hD35}, {1'h0, 8'h08, 32'h35},
    {1'h0, 8'h0C, 32'h18}, {1'h1, 8'h18, 32'h1F},
    {1'h1, 8'h1C, 32'hFF}, {1'h1, 8'h04, 32'h2BF},
    {1'h0, 8'h1C, 32'h00}, {1'h0, 8'h0C, 32'h1C},
    {1'h1, 8'h04, 32'h11F}, {1'h0, 8'h08, 32'h35},
    {1'h0, 8'h0C, 32'h18}, {1'h1, 8'h04, 32'h29F},
    {1'h0, 8'h08, 32'h01}, {1'h0, 8'h1C, 32'h00},
    {1'h1, 8'h18, 32'h00}, {1'h1, 8'h1C, 32'hA0},
    {1'h1, 8'h04, 32'h120}, {1'h0, 8'h1C, 32'hA1},
    {1'h1, 8'h0C, 32'hFF}, {1'h0, 8'h0C, 32'h1C},
    {1'h1, 8'h0C, 32'h00}, {1'h0, 8'h0C, 32'h18},
    {1'h1, 8'h00, 32'h2}, {1'h1, 8'h00, 32'h6},
    {1'h0, 8'h0C, 32'h08}, {1'h1, 8'h00, 32'h1},
    {1'h1, 8'h10, 32'h33}, {1'h1, 8'h14, 32'h44},
    {1'h1, 8'h04, 32'h004}, {1'h0, 8'h0C, 32'h18},
    {1'h0, 8'h10, 32'h00}, {1'h0, 8'h14, 32'h00},
    {1'h1, 8'h00, 32'h0}, {1'h1, 8'h10, 32'h33},
    {1'h1, 8'h14, 32'h44}, {1'h1, 8'h04, 32'h004},
    {1'h0, 8'h10, 32'h00}, {1'h0, 8'h14, 32'h44}};
  // Free running bus clock
  always #12.5 pclk = ~pclk;
  ciex_top i_ciex_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .skip_ff, .wreg_ff);
  // Closing report
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One transfer; pready is sampled only at rising edges
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      err_count++;
      test_done();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Outputs launched at the answer edge settle before callers look
    @(negedge pclk);
  endtask
  // Table, then skip, refusal and reset cases
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i][40], rows[i][39:32], rows[i][31:0]);
      if (!rows[i][40]) chk("table read", rd, rows[i][31:0]);
    end
    $display("table test done");
    apb(1'h1, 8'h18, 32'h05);
    apb(1'h1, 8'h1C, 32'hFF);
    apb(1'h1, 8'h04, 32'h3E5);
    chk("skip flag", {31'h0, skip_ff}, 32'h1);
    apb(1'h1, 8'h04, 32'hD0F);
    chk("skip clear", {31'h0, skip_ff}, 32'h0);
    apb(1'h0, 8'h08, 32'h0);
    chk("W after skip", rd, 32'h01);
    apb(1'h0, 8'h0C, 32'h0);
    chk("status after skip", rd, 32'h18);
    apb(1'h1, 8'h04, 32'h3E5);
    apb(1'h0, 8'h1C, 32'h0);
    chk("skip file", rd, 32'h01);
    chk("no skip", {31'h0, skip_ff}, 32'h0);
    $display("skip test done");
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped error", {31'h0, slv}, 32'h1);
    $display("refusal test done");
    @(posedge pclk);
    presetn <= 1'h0;
    @(negedge pclk);
    chk("W in reset", {24'h0, wreg_ff}, 32'h0);
    @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h0C, 32'h0);
    chk("status reset", rd, 32'h18);
    $display("reset test done");
    test_done();
  end
endmodule
